// ---- core/uefc_pkg.sv ----
package uefc_pkg;

  // request header fields
  localparam logic [7:0] RT_DEVICE         = 8'h00;
  localparam logic [7:0] RT_IFACE          = 8'h01;
  localparam logic [7:0] RT_ENDPOINT       = 8'h02;
  localparam logic [7:0] RQ_CLEAR_FEATURE  = 8'h01;
  localparam logic [7:0] RQ_SET_FEATURE    = 8'h03;
  localparam logic [7:0] RQ_SET_CONFIG     = 8'h09;
  localparam logic [7:0] RQ_SET_IFACE      = 8'h0b;
  localparam logic [7:0] FS_STALL          = 8'h00;
  localparam logic [7:0] FS_WAKEUP         = 8'h01;
  localparam logic [7:0] DT_CONFIG         = 8'h02;
  localparam logic [7:0] EP_RSVD_MASK      = 8'h78;
  localparam int         EP_DIR_BIT        = 7;

  // byte positions inside the eight-byte request
  localparam int         SETUP_LEN         = 8;
  localparam int         SB_TYPE           = 0;
  localparam int         SB_REQ            = 1;
  localparam int         SB_VALL           = 2;
  localparam int         SB_VALH           = 3;
  localparam int         SB_IDXL           = 4;
  localparam int         SB_LENL           = 6;
  localparam int         SB_LENH           = 7;

  // descriptor header bytes read before the data stage
  localparam logic [2:0] FETCH_CNT         = 3'h4;
  localparam logic [2:0] DESC_LEN_OFS      = 3'h0;
  localparam logic [2:0] DESC_TOTL_OFS     = 3'h2;
  localparam logic [2:0] DESC_TOTH_OFS     = 3'h3;

  localparam int         MAX_PKT_BYTES     = 64;
  localparam int         NUM_EP            = 16;
  localparam logic [15:0] SETUP_BUF_ADDR   = 16'h0100;

  // register offsets
  localparam logic [7:0] REG_EP0_CONTROL_STATUS         = 8'h00;
  localparam logic [7:0] REG_PTRH          = 8'h01;
  localparam logic [7:0] REG_PTRL          = 8'h02;
  localparam logic [7:0] REG_WAKE          = 8'h03;
  localparam logic [4:0] REG_SETUP_PAGE    = 5'h01;
  localparam logic [3:0] REG_EPCS_PAGE     = 4'h1;
  localparam logic [3:0] REG_EPBC_PAGE     = 4'h2;

  // field positions
  localparam int         EP0_STALL_BIT     = 0;
  localparam int         EP0_HOLD_BIT      = 1;
  localparam int         EP0_AUTO_BIT      = 2;
  localparam int         WAKE_EN_BIT       = 0;
  localparam int         CS_STALL_BIT      = 0;
  localparam int         CS_BUSY_BIT       = 1;
  localparam int         CS_TOGGLE_BIT     = 2;

  typedef enum logic [1:0] {
    HS_NAK   = 2'h0,
    HS_ACK   = 2'h1,
    HS_STALL = 2'h2,
    HS_DATA  = 2'h3
  } uefc_hs_t;

endpackage

// ---- core/uefc_ep0_ctrl.sv ----
// Contract
// - Set Feature device, selector wakeup, sets remote wakeup enable; no data stage.
// - Set Feature endpoint stall sets stall of endpoint named in byte 4.
// - Stall request: set stall, reset toggle, firmware clears handshake hold by writing one.
// - Stall request frees IN busy and rearms OUT byte count.
// - Set Interface restores all endpoints the same way.
// - Core keeps toggles; firmware edits them only during stall, configuration, interface requests.
// - Clear Feature device, selector wakeup, clears remote wakeup enable.
// - Clear Feature endpoint stall clears stall of endpoint named in byte 4.
// - Stall stays until host clears it with Clear Feature.
// - Sixteen-bit setup data pointer in high and low byte registers.
// - Eight request bytes copied to RAM buffer; setup-available request raised.
// - Low pointer write starts automatic data stage, packets of at most 64 bytes.
// - Firmware serves descriptors by clearing hold and loading pointer, copying nothing.
// - Setup-available and IN-done requests stay active during automatic transfer.
// - Stall is bit 0 of endpoint status; stalled endpoint answers STALL.
// - Endpoint-zero stall holds until the next setup starts, then clears itself.
// - Bytes sent are the smaller of requested and true descriptor length.
`timescale 1ns/10ps
`default_nettype none

module uefc_ep0_ctrl #(
  parameter logic [15:0] SETUP_BASE = uefc_pkg::SETUP_BUF_ADDR,
  parameter int          MAX_PKT    = uefc_pkg::MAX_PKT_BYTES
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            ce,
  input  wire logic [7:0]      regAddr,
  input  wire logic [7:0]      regWdata,
  input  wire logic            regWrite,
  input  wire logic            regRead,
  output logic [7:0]           regRdata,
  input  wire logic            setupStart,
  input  wire logic            setupByteValid,
  input  wire logic [7:0]      setupByte,
  input  wire logic            ep0InToken,
  input  wire logic            ep0OutToken,
  input  wire logic            ep0InAck,
  output logic                 ep0HsValid,
  output uefc_pkg::uefc_hs_t   ep0HsCode,
  output logic                 inValid,
  output logic [7:0]           inByte,
  output logic                 inLast,
  output logic                 statusDone,
  input  wire logic            tokValid,
  input  wire logic [3:0]      tokEp,
  input  wire logic            epAckValid,
  input  wire logic [3:0]      epAckEp,
  output logic                 hsValid,
  output uefc_pkg::uefc_hs_t   hsCode,
  output logic                 hsData1,
  output logic [15:0]          ramAddr,
  output logic                 ramWrEn,
  output logic [7:0]           ramWrData,
  output logic                 ramRdEn,
  input  wire logic [7:0]      ramRdData,
  output logic                 setupAvailIrq,
  output logic                 ep0InDoneIrq,
  output logic                 remoteWakeEn
);

  localparam int PKT_W = $clog2(MAX_PKT + 1);

  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_FETCH    = 7'h02,
    ST_CALC     = 7'h04,
    ST_WAIT_IN  = 7'h08,
    ST_SEND     = 7'h10,
    ST_WAIT_ACK = 7'h20,
    ST_STATUS   = 7'h40
  } uefc_state_t;

  function automatic logic [15:0] minLen(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic reqIs(input logic [7:0] t, input logic [7:0] r, input logic [7:0] s,
                                 input logic [7:0] et, input logic [7:0] er, input logic [7:0] es);
    return (t == et) && (r == er) && (s == es);
  endfunction

  uefc_state_t        state_reg;
  uefc_state_t        state_next;
  logic [7:0]         setupBuf_reg [uefc_pkg::SETUP_LEN];
  logic [3:0]         setupIdx_reg;
  logic               setupDone_reg;
  logic               setupWr_reg;
  logic [15:0]        setupWrAddr_reg;
  logic [7:0]         setupWrData_reg;
  logic               ep0Stall_reg;
  logic               hold_reg;
  logic               togWindow_reg;
  logic               wake_reg;
  logic [7:0]         ptrHigh_reg;
  logic [7:0]         ptrLow_reg;
  logic [15:0]        pktBase_reg;
  logic [15:0]        remLen_reg;
  logic               lenIsReq_reg;
  logic [2:0]         fetchCnt_reg;
  logic [7:0]         descLen_reg;
  logic [7:0]         descTotL_reg;
  logic [7:0]         descTotH_reg;
  logic [PKT_W-1:0]   sendCnt_reg;
  logic               rdPend_reg;
  logic               inValid_reg;
  logic [7:0]         inByte_reg;
  logic               inLast_reg;
  logic               ep0HsValid_reg;
  uefc_pkg::uefc_hs_t ep0HsCode_reg;
  logic               statusDone_reg;
  logic               inDoneIrq_reg;
  logic [uefc_pkg::NUM_EP-1:0] stall_reg;
  logic [uefc_pkg::NUM_EP-1:0] busy_reg;
  logic [uefc_pkg::NUM_EP-1:0] tog_reg;
  logic               hsValid_reg;
  uefc_pkg::uefc_hs_t hsCode_reg;
  logic               hsData1_reg;
  logic [7:0]         regRdata_reg;

  // request decode, valid once all eight bytes are in
  wire  [7:0]  rqType    = setupBuf_reg[uefc_pkg::SB_TYPE];
  wire  [7:0]  rqCode    = setupBuf_reg[uefc_pkg::SB_REQ];
  wire  [7:0]  rqSel     = setupBuf_reg[uefc_pkg::SB_VALL];
  wire  [7:0]  rqEp      = setupBuf_reg[uefc_pkg::SB_IDXL];
  wire  [15:0] reqLen    = {setupBuf_reg[uefc_pkg::SB_LENH], setupBuf_reg[uefc_pkg::SB_LENL]};
  wire  [3:0]  rqEpIdx   = {rqEp[uefc_pkg::EP_DIR_BIT], rqEp[2:0]};
  wire         rqEpOk    = (rqEp & uefc_pkg::EP_RSVD_MASK) == 8'h00;
  wire         isSetWake = reqIs(rqType, rqCode, rqSel, uefc_pkg::RT_DEVICE,
                                 uefc_pkg::RQ_SET_FEATURE, uefc_pkg::FS_WAKEUP);
  wire         isClrWake = reqIs(rqType, rqCode, rqSel, uefc_pkg::RT_DEVICE,
                                 uefc_pkg::RQ_CLEAR_FEATURE, uefc_pkg::FS_WAKEUP);
  wire         isSetStall = rqEpOk && reqIs(rqType, rqCode, rqSel, uefc_pkg::RT_ENDPOINT,
                                 uefc_pkg::RQ_SET_FEATURE, uefc_pkg::FS_STALL);
  wire         isClrStall = rqEpOk && reqIs(rqType, rqCode, rqSel, uefc_pkg::RT_ENDPOINT,
                                 uefc_pkg::RQ_CLEAR_FEATURE, uefc_pkg::FS_STALL);
  wire         isSetIface = (rqType == uefc_pkg::RT_IFACE) && (rqCode == uefc_pkg::RQ_SET_IFACE);
  wire         isSetCfg  = (rqType == uefc_pkg::RT_DEVICE) && (rqCode == uefc_pkg::RQ_SET_CONFIG);

  // register strobes
  wire         ep0CsWr   = regWrite && (regAddr == uefc_pkg::REG_EP0_CONTROL_STATUS);
  wire         ptrHighWr = regWrite && (regAddr == uefc_pkg::REG_PTRH);
  wire         ptrLowWr  = regWrite && (regAddr == uefc_pkg::REG_PTRL);
  wire         wakeWr    = regWrite && (regAddr == uefc_pkg::REG_WAKE);
  wire         epCsWr    = regWrite && (regAddr[7:4] == uefc_pkg::REG_EPCS_PAGE);
  wire         epBcWr    = regWrite && (regAddr[7:4] == uefc_pkg::REG_EPBC_PAGE);
  wire         setupRd   = regAddr[7:3] == uefc_pkg::REG_SETUP_PAGE;
  wire         epCsRd    = regAddr[7:4] == uefc_pkg::REG_EPCS_PAGE;
  wire         togAllowed = togWindow_reg && hold_reg;

  // automatic data stage
  wire         autoBusy  = state_reg != ST_IDLE;
  wire  [15:0] pktLen16  = minLen(remLen_reg, 16'(MAX_PKT));
  wire  [PKT_W-1:0] pktLen = pktLen16[PKT_W-1:0];
  wire         lastPkt   = (pktLen < PKT_W'(MAX_PKT)) || ((remLen_reg == pktLen16) && lenIsReq_reg);
  wire  [15:0] trueLen   = (setupBuf_reg[uefc_pkg::SB_VALH] == uefc_pkg::DT_CONFIG) ?
                           {descTotH_reg, descTotL_reg} : {8'h00, descLen_reg};
  wire         fetchRd   = (state_reg == ST_FETCH) && (fetchCnt_reg < uefc_pkg::FETCH_CNT);
  wire         sendRd    = (state_reg == ST_SEND) && (sendCnt_reg < pktLen);
  wire         sendFinish = (state_reg == ST_SEND) && (sendCnt_reg == pktLen);
  wire  [2:0]  capIdx    = fetchCnt_reg - 3'h1;
  wire  [15:0] rdAddr    = (state_reg == ST_FETCH) ? pktBase_reg + 16'(fetchCnt_reg)
                                                   : pktBase_reg + 16'(sendCnt_reg);
  wire         startSend = ep0InToken && ((state_reg == ST_WAIT_IN) || (state_reg == ST_WAIT_ACK));
  // status stage: automatic stage acks by itself, a manual one waits for the hold release
  wire         statusOk  = ep0OutToken && !ep0Stall_reg &&
                           ((state_reg == ST_STATUS) || (state_reg == ST_WAIT_IN) ||
                            (state_reg == ST_WAIT_ACK) || ((state_reg == ST_IDLE) && !hold_reg));

  wire  [7:0]  ep0CsWord = (8'(ep0Stall_reg) << uefc_pkg::EP0_STALL_BIT) |
                           (8'(hold_reg) << uefc_pkg::EP0_HOLD_BIT) |
                           (8'(autoBusy) << uefc_pkg::EP0_AUTO_BIT);
  wire  [7:0]  epCsWord  = (8'(stall_reg[regAddr[3:0]]) << uefc_pkg::CS_STALL_BIT) |
                           (8'(busy_reg[regAddr[3:0]]) << uefc_pkg::CS_BUSY_BIT) |
                           (8'(tog_reg[regAddr[3:0]]) << uefc_pkg::CS_TOGGLE_BIT);
  wire  [7:0]  readVal   = (regAddr == uefc_pkg::REG_EP0_CONTROL_STATUS) ? ep0CsWord :
                           (regAddr == uefc_pkg::REG_PTRH)  ? ptrHigh_reg :
                           (regAddr == uefc_pkg::REG_PTRL)  ? ptrLow_reg :
                           (regAddr == uefc_pkg::REG_WAKE)  ? (8'(wake_reg) << uefc_pkg::WAKE_EN_BIT) :
                           setupRd ? setupBuf_reg[regAddr[2:0]] :
                           epCsRd  ? epCsWord : 8'h00;

  assign regRdata      = regRdata_reg;
  assign ramWrEn       = setupWr_reg;
  assign ramWrData     = setupWrData_reg;
  assign ramRdEn       = fetchRd || sendRd;
  assign ramAddr       = setupWr_reg ? setupWrAddr_reg : rdAddr;
  assign inValid       = inValid_reg;
  assign inByte        = inByte_reg;
  assign inLast        = inLast_reg;
  assign ep0HsValid    = ep0HsValid_reg;
  assign ep0HsCode     = ep0HsCode_reg;
  assign statusDone    = statusDone_reg;
  assign hsValid       = hsValid_reg;
  assign hsCode        = hsCode_reg;
  assign hsData1       = hsData1_reg;
  assign setupAvailIrq = setupDone_reg;
  assign ep0InDoneIrq  = inDoneIrq_reg;
  assign remoteWakeEn  = wake_reg;

  // read data stands for the one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata_reg <= 8'h00;
    end else if (ce) begin
      regRdata_reg <= regRead ? readVal : 8'h00;
    end
  end

  // request capture into flops and the RAM buffer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setupIdx_reg    <= 4'h0;
      setupDone_reg   <= 1'b0;
      setupWr_reg     <= 1'b0;
      setupWrAddr_reg <= 16'h0000;
      setupWrData_reg <= 8'h00;
      for (int i = 0; i < uefc_pkg::SETUP_LEN; i++) setupBuf_reg[i] <= 8'h00;
    end else if (ce) begin
      setupWr_reg   <= 1'b0;
      setupDone_reg <= 1'b0;
      if (setupStart) begin
        setupIdx_reg <= 4'h0;
      end else if (setupByteValid && (setupIdx_reg < 4'(uefc_pkg::SETUP_LEN))) begin
        setupBuf_reg[setupIdx_reg[2:0]] <= setupByte;
        setupWr_reg     <= 1'b1;
        setupWrAddr_reg <= SETUP_BASE + 16'(setupIdx_reg);
        setupWrData_reg <= setupByte;
        setupIdx_reg    <= setupIdx_reg + 4'h1;
        setupDone_reg   <= setupIdx_reg == 4'(uefc_pkg::SETUP_LEN - 1);
      end
    end
  end

  // endpoint-zero control, wakeup and pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ep0Stall_reg  <= 1'b0;
      hold_reg      <= 1'b0;
      togWindow_reg <= 1'b0;
      wake_reg      <= 1'b0;
      ptrHigh_reg   <= 8'h00;
      ptrLow_reg    <= 8'h00;
    end else if (ce) begin
      // set wins: a firmware stall in the setup cycle survives
      if (ep0CsWr && regWdata[uefc_pkg::EP0_STALL_BIT]) begin
        ep0Stall_reg <= 1'b1;
      end else if (setupStart) begin
        ep0Stall_reg <= 1'b0;
      end
      if (setupDone_reg) begin
        hold_reg      <= 1'b1;
        togWindow_reg <= isSetStall || isSetCfg || isSetIface;
      end else if (ep0CsWr && regWdata[uefc_pkg::EP0_HOLD_BIT]) begin
        hold_reg <= 1'b0;
      end
      if (setupDone_reg && isSetWake) begin
        wake_reg <= 1'b1;
      end else if (setupDone_reg && isClrWake) begin
        wake_reg <= 1'b0;
      end else if (wakeWr) begin
        wake_reg <= regWdata[uefc_pkg::WAKE_EN_BIT];
      end
      if (ptrHighWr) ptrHigh_reg <= regWdata;
      if (ptrLowWr) ptrLow_reg <= regWdata;
    end
  end

  // bulk endpoint stall, busy and toggle; hardware set wins over clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_reg <= '0;
      busy_reg  <= '0;
      tog_reg   <= '0;
    end else if (ce) begin
      for (int e = 0; e < uefc_pkg::NUM_EP; e++) begin
        if (setupDone_reg && isClrStall && (rqEpIdx == 4'(e))) begin
          stall_reg[e] <= 1'b0;
          tog_reg[e]   <= 1'b0;
        end
        if ((setupDone_reg && isSetStall && (rqEpIdx == 4'(e))) ||
            (epCsWr && (regAddr[3:0] == 4'(e)) && regWdata[uefc_pkg::CS_STALL_BIT])) begin
          stall_reg[e] <= 1'b1;
        end
        if (epAckValid && (epAckEp == 4'(e))) begin
          tog_reg[e]  <= ~tog_reg[e];
          busy_reg[e] <= 1'b0;
        end
        if (epCsWr && (regAddr[3:0] == 4'(e))) begin
          busy_reg[e] <= regWdata[uefc_pkg::CS_BUSY_BIT];
          if (togAllowed) tog_reg[e] <= regWdata[uefc_pkg::CS_TOGGLE_BIT];
        end
        if (epBcWr && (regAddr[3:0] == 4'(e))) busy_reg[e] <= 1'b1;
        if (setupDone_reg && (isSetIface || (isSetStall && (rqEpIdx == 4'(e))))) begin
          busy_reg[e] <= ~e[3];
          if (isSetStall) tog_reg[e] <= 1'b0;
        end
      end
    end
  end

  // bulk token answers, one cycle after the token
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hsValid_reg <= 1'b0;
      hsCode_reg  <= uefc_pkg::HS_NAK;
      hsData1_reg <= 1'b0;
    end else if (ce) begin
      hsValid_reg <= tokValid;
      if (tokValid) begin
        hsData1_reg <= tog_reg[tokEp];
        hsCode_reg  <= stall_reg[tokEp] ? uefc_pkg::HS_STALL :
                       busy_reg[tokEp]  ? uefc_pkg::HS_ACK : uefc_pkg::HS_NAK;
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    if (setupStart) begin
      state_next = ST_IDLE;
    end else if (ptrLowWr) begin
      state_next = ST_FETCH;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          state_next = ST_IDLE;
        end
        ST_FETCH: begin
          if (fetchCnt_reg == uefc_pkg::FETCH_CNT) state_next = ST_CALC;
        end
        ST_CALC: begin
          state_next = ST_WAIT_IN;
        end
        ST_WAIT_IN: begin
          if (startSend) state_next = ST_SEND;
          else if (ep0OutToken) state_next = ST_IDLE;
        end
        ST_SEND: begin
          if (sendFinish) state_next = ST_WAIT_ACK;
        end
        ST_WAIT_ACK: begin
          if (ep0InAck) state_next = lastPkt ? ST_STATUS : ST_WAIT_IN;
          else if (startSend) state_next = ST_SEND;
          else if (ep0OutToken) state_next = ST_IDLE;
        end
        ST_STATUS: begin
          if (ep0OutToken) state_next = ST_IDLE;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // automatic descriptor stage datapath
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ST_IDLE;
      pktBase_reg  <= 16'h0000;
      remLen_reg   <= 16'h0000;
      lenIsReq_reg <= 1'b0;
      fetchCnt_reg <= 3'h0;
      descLen_reg  <= 8'h00;
      descTotL_reg <= 8'h00;
      descTotH_reg <= 8'h00;
      sendCnt_reg  <= '0;
      rdPend_reg   <= 1'b0;
    end else if (ce) begin
      state_reg  <= state_next;
      rdPend_reg <= fetchRd || sendRd;
      if (ptrLowWr) begin
        pktBase_reg  <= {ptrHigh_reg, regWdata};
        fetchCnt_reg <= 3'h0;
      end else if (fetchRd) begin
        fetchCnt_reg <= fetchCnt_reg + 3'h1;
      end
      if ((state_reg == ST_FETCH) && rdPend_reg) begin
        if (capIdx == uefc_pkg::DESC_LEN_OFS) descLen_reg <= ramRdData;
        if (capIdx == uefc_pkg::DESC_TOTL_OFS) descTotL_reg <= ramRdData;
        if (capIdx == uefc_pkg::DESC_TOTH_OFS) descTotH_reg <= ramRdData;
      end
      if (state_reg == ST_CALC) begin
        remLen_reg   <= minLen(reqLen, trueLen);
        lenIsReq_reg <= reqLen <= trueLen;
      end
      if (startSend) begin
        sendCnt_reg <= '0;
      end else if (sendRd) begin
        sendCnt_reg <= sendCnt_reg + PKT_W'(1);
      end
      if ((state_reg == ST_WAIT_ACK) && ep0InAck) begin
        pktBase_reg <= pktBase_reg + pktLen16;
        remLen_reg  <= remLen_reg - pktLen16;
      end
    end
  end

  // endpoint-zero answers and IN byte stream
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inValid_reg    <= 1'b0;
      inByte_reg     <= 8'h00;
      inLast_reg     <= 1'b0;
      ep0HsValid_reg <= 1'b0;
      ep0HsCode_reg  <= uefc_pkg::HS_NAK;
      statusDone_reg <= 1'b0;
      inDoneIrq_reg  <= 1'b0;
    end else if (ce) begin
      inValid_reg    <= rdPend_reg && (state_reg != ST_FETCH);
      inLast_reg     <= sendFinish;
      if (rdPend_reg) inByte_reg <= ramRdData;
      ep0HsValid_reg <= ep0InToken || ep0OutToken;
      ep0HsCode_reg  <= ep0Stall_reg ? uefc_pkg::HS_STALL :
                        startSend    ? uefc_pkg::HS_DATA :
                        statusOk     ? uefc_pkg::HS_ACK : uefc_pkg::HS_NAK;
      statusDone_reg <= statusOk;
      inDoneIrq_reg  <= (state_reg == ST_WAIT_ACK) && ep0InAck;
    end
  end

endmodule

`default_nettype wire

// ---- tb/uefc_ep0_props.sv ----
`timescale 1ns/10ps
`default_nettype none
module uefc_ep0_props (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               ce,
  input wire logic               regWrite,
  input wire logic               tokValid,
  input wire logic               hsValid,
  input wire logic               ep0InToken,
  input wire logic               ep0OutToken,
  input wire logic               ep0InAck,
  input wire logic               ep0HsValid,
  input wire uefc_pkg::uefc_hs_t ep0HsCode,
  input wire logic               statusDone,
  input wire logic               inValid,
  input wire logic               inLast,
  input wire logic               setupAvailIrq,
  input wire logic               ep0InDoneIrq,
  input wire logic               remoteWakeEn
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  bulk_answer_a: assert property (ce && tokValid |=> hsValid) else $error("no bulk answer");
  bulk_quiet_a: assert property (ce && !tokValid |=> !hsValid) else $error("bulk answer w/o token");
  ep0_answer_a: assert property (ce && (ep0InToken || ep0OutToken) |=> ep0HsValid) else $error("no ep0 answer");
  status_ack_a: assert property (statusDone |-> ep0HsValid && ep0HsCode == uefc_pkg::HS_ACK)
    else $error("status done without ack");
  last_ends_a: assert property (ce && inLast |=> !inValid) else $error("byte after last");
  avail_pulse_a: assert property (ce && setupAvailIrq |=> !setupAvailIrq) else $error("irq too long");
  in_done_a: assert property ($rose(ep0InDoneIrq) |-> $past(ep0InAck)) else $error("irq without ack");
  wake_cause_a: assert property ($changed(remoteWakeEn) |-> $past(setupAvailIrq) || $past(regWrite))
    else $error("wakeup changed alone");
  cover property (statusDone);
  cover property (ce && inLast);
  cover property (remoteWakeEn);
endmodule
bind uefc_ep0_ctrl uefc_ep0_props u_props (.clk, .rst_n, .ce, .regWrite, .tokValid, .hsValid, .ep0InToken,
  .ep0OutToken, .ep0InAck, .ep0HsValid, .ep0HsCode, .statusDone, .inValid, .inLast, .setupAvailIrq,
  .ep0InDoneIrq, .remoteWakeEn);
`default_nettype wire

// ---- tb/uefc_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module uefc_host_model (
  input  wire logic       clk,
  output var  logic       setupStart,
  output var  logic       setupByteValid,
  output var  logic [7:0] setupByte,
  output var  logic       ep0InToken,
  output var  logic       ep0OutToken,
  output var  logic       ep0InAck,
  output var  logic       tokValid,
  output var  logic [3:0] tokEp
);
  initial {setupStart, setupByteValid, setupByte, ep0InToken, ep0OutToken, ep0InAck, tokValid, tokEp} = '0;
  // byte 0 in low bits; stalls are only lifted by such a request
  task automatic req(input logic [63:0] r);
    @(posedge clk);
    setupStart <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      setupStart <= 1'b0;
      setupByteValid <= 1'b1;
      setupByte <= r[i*8 +: 8];
    end
    @(posedge clk);
    setupByteValid <= 1'b0;
    setupByte <= ~setupByte;
    repeat (4) @(posedge clk);
  endtask
  task automatic tok(input logic [3:0] ep);
    @(posedge clk);
    tokValid <= 1'b1;
    tokEp <= ep;
    @(posedge clk);
    tokValid <= 1'b0;
    tokEp <= ~ep;
    #1;
  endtask
  // 0 in token, 1 out token, 2 ack
  task automatic ep0(input logic [1:0] k);
    @(posedge clk);
    ep0InToken <= k == 2'h0;
    ep0OutToken <= k == 2'h1;
    ep0InAck <= k == 2'h2;
    @(posedge clk);
    {ep0InToken, ep0OutToken, ep0InAck} <= 3'h0;
    #1;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_usb_ep0_feature_and_descriptor_control.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_usb_ep0_feature_and_descriptor_control;
  logic clk, rst_n, regWrite, regRead, ce, epAckValid;
  logic [7:0] regAddr, regWdata, ramRdData, d, n, regRdata, inByte, ramWrData, wrSeen;
  logic [3:0] epAckEp;
  logic ep0HsValid, inValid, inLast, statusDone, hsValid, hsData1, ramWrEn, ramRdEn;
  logic setupAvailIrq, ep0InDoneIrq, remoteWakeEn, setupStart, setupByteValid, ep0InToken;
  logic ep0OutToken, ep0InAck, tokValid;
  logic [7:0] setupByte;
  logic [3:0] tokEp;
  logic [15:0] ramAddr;
  uefc_pkg::uefc_hs_t ep0HsCode, hsCode;
  int errorCnt, compares;
  uefc_ep0_ctrl uut (.clk, .rst_n, .ce, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .setupStart,
    .setupByteValid, .setupByte, .ep0InToken, .ep0OutToken, .ep0InAck, .ep0HsValid, .ep0HsCode, .inValid,
    .inByte, .inLast, .statusDone, .tokValid, .tokEp, .epAckValid, .epAckEp, .hsValid, .hsCode,
    .hsData1, .ramAddr, .ramWrEn, .ramWrData, .ramRdEn, .ramRdData, .setupAvailIrq, .ep0InDoneIrq, .remoteWakeEn);
  uefc_host_model host (.clk, .setupStart, .setupByteValid, .setupByte, .ep0InToken, .ep0OutToken, .ep0InAck,
    .tokValid, .tokEp);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // descriptor at 0x0200 claims 5 bytes, body bytes echo the address
  always @(posedge clk) ramRdData <= ramAddr == 16'h0200 ? 8'h05 : ramAddr[7:0];
  // request byte 6 as the capture logic wrote it to RAM
  always @(posedge clk)
    if (ramWrEn === 1'b1 && ramAddr == uefc_pkg::SETUP_BUF_ADDR + 16'h0006) wrSeen <= ramWrData;
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      errorCnt++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask
  task automatic tally_and_finish();
    if (errorCnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    {rst_n, regWrite, regRead, regAddr, regWdata, epAckValid, epAckEp} = '0;
    ce = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h7f); chk(d, 8'h00);
    host.req(64'h0000_0000_0001_0300); rd(8'h03); chk(d & 8'h01, 8'h01);
    host.req(64'h0000_0000_0001_0100); rd(8'h03); chk(d & 8'h01, 8'h00);
    host.req(64'h0000_0081_0000_0302); wr(8'h00, 8'h02); wr(8'h19, 8'h04);
    host.tok(4'h9); chk(hsCode, uefc_pkg::HS_STALL);
    rd(8'h19); chk(d & 8'h07, 8'h01);
    wr(8'h19, 8'h00); host.tok(4'h9); chk(hsCode, uefc_pkg::HS_STALL);
    host.req(64'h0000_0081_0000_0102); host.tok(4'h9); chk(hsCode, uefc_pkg::HS_NAK);
    chk(hsData1, 1'b0);
    host.req(64'h0000_0002_0000_0302); rd(8'h12); chk(d & 8'h03, 8'h03);
    wr(8'h29, 8'h00); host.tok(4'h9); chk(hsCode, uefc_pkg::HS_ACK);
    host.req(64'h0000_0000_0000_0b01); host.tok(4'h9); chk(hsCode, uefc_pkg::HS_NAK);
    @(posedge clk);
    epAckValid <= 1'b1;
    epAckEp <= 4'h9;
    @(posedge clk);
    epAckValid <= 1'b0;
    host.tok(4'h9);
    chk(hsData1, 1'b1);
    // enable low: the token on endpoint 1 must not replace the held answer
    ce <= 1'b0;
    host.tok(4'h1);
    chk(hsData1, 1'b1);
    ce <= 1'b1;
    host.req(64'h0003_0000_0100_0680); wr(8'h00, 8'h02); wr(8'h01, 8'h02); wr(8'h02, 8'h00);
    rd(8'h00); chk(d & 8'h06, 8'h04);
    rd(8'h01); chk(d, 8'h02);
    chk(wrSeen, 8'h03);
    repeat (10) @(posedge clk);
    host.ep0(2'h0); chk(ep0HsCode, uefc_pkg::HS_DATA);
    n = 8'h00;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      #1;
      if (inValid === 1'b1) begin
        chk(inByte, n == 8'h00 ? 8'h05 : n);
        n++;
      end
    end
    chk(n, 8'h03);
    host.ep0(2'h2); chk(ep0InDoneIrq, 1'b1);
    host.ep0(2'h1); chk(statusDone, 1'b1);
    wr(8'h00, 8'h01); host.ep0(2'h0); chk(ep0HsCode, uefc_pkg::HS_STALL);
    host.req(64'h0000_0000_0001_0100); rd(8'h00); chk(d & 8'h01, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
